//--- usb_fc_top.sv
/*
  USB device function control: frame number, control, event enable,
  event flags, device address, module enable and timestamp registers,
  plus the 2 KiB buffer memory, all behind one AHB-Lite slave.
  Assumes the serial engine and timer run on hclk, so their signals
  enter without synchronisers; only single transfers are issued.
*/
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps

// Summary of operation
// - start-of-frame loads frame number, upper bits zero
// - unlocked pseudo start-of-frame increments frame number
// - function enable clear ignores all transactions
// - bus reset clears function enable
// - remote wakeup bit pulses once, self-clears
// - reset-connection bit lets bus reset reset module
// - enabled flags raise interrupt request
// - bus reset flag survives module reset
// - suspend and resume events set flags
// - setup transaction sets setup flag
// - setup flag forces endpoint-0 NAK
// - setup over pending setup sets overwrite flag
// - seven-bit device address held for software
// - register writes, except to module enable itself, need module enable set
// - reserved bits read zero, ignore writes
// - buffer space, endpoint-0 buffers, setup block mapped
// - buffer memory also holds endpoint descriptors
// - buffer memory takes byte and word access
// - timestamp trigger latches module timer value
module usb_fc_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial engine and timer, same clock
  input wire usb_fc_pkg::usb_evt_t usb_evt,
  input wire logic ts_trigger,
  input wire logic [15:0] timer_value,
  // function side controls
  output logic txn_enable,
  output logic ep0_force_nak,
  output logic wakeup_pulse,
  output logic module_reset,
  output logic data_dir_in,
  output logic [6:0] device_address,
  output logic irq
);

  // bus engine states; reads take two wait states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RD_MEM,
    BUS_RD_OUT
  } bus_state_t;

  // byte lanes of a transfer from its size and low address
  function automatic logic [3:0] lanes(input logic [2:0] sz,
                                       input logic [1:0] a);
    case (sz)
      3'h0: lanes = 4'h1 << a;
      3'h1: lanes = a[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  endfunction

  // word match against a register offset
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // bus state
  bus_state_t state_q;
  logic [11:0] addr_q; // address of the transfer in data phase
  logic [3:0] be_q; // its byte lanes
  logic wr_pend_q; // write data phase in progress
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;

  // register state
  logic [7:0] ctl_q; // function control
  logic [7:0] ie_q; // event interrupt enable
  logic [7:0] flags_q; // event flags
  logic [6:0] adr_q; // device address field
  logic moden_q; // module enable
  logic [15:0] ts_q; // timestamp
  logic [10:0] frame_q; // from the tracker

  // derived outputs
  logic wake_q;
  logic modrst_q;
  logic nak_q;
  logic irq_q;

  // address phase accepted when selected, active and bus ready
  logic acc;
  assign acc = hsel && htrans[1] && hready;

  // write commits at the end of its single data phase
  logic wr_commit;
  assign wr_commit = wr_pend_q && (state_q == BUS_IDLE);

  // register or memory target
  logic to_reg;
  assign to_reg = addr_q[11];

  // register writes, all but module enable gated by module enable
  logic reg_wr;
  assign reg_wr = wr_commit && to_reg && moden_q && be_q[0];
  logic wr_ctl;
  logic wr_ie;
  logic wr_flags;
  logic wr_adr;
  assign wr_ctl = reg_wr && hit(addr_q, usb_fc_pkg::OFS_CTL);
  assign wr_ie = reg_wr && hit(addr_q, usb_fc_pkg::OFS_IE);
  assign wr_flags = reg_wr && hit(addr_q, usb_fc_pkg::OFS_FLAGS);
  assign wr_adr = reg_wr && hit(addr_q, usb_fc_pkg::OFS_DEVADR);
  // module enable must stay writable, else it could never be set
  logic wr_moden;
  assign wr_moden = wr_commit && to_reg && be_q[0] &&
                    hit(addr_q, usb_fc_pkg::OFS_MODEN);

  // low byte of write data
  logic [7:0] wbyte;
  assign wbyte = hwdata[7:0];

  // bus reset also resets the module when connected
  logic soft_rst;
  assign soft_rst = usb_evt.bus_reset &&
                    ctl_q[usb_fc_pkg::BIT_BUS_RESET_RESETS_MODULE];

  // bus engine: capture address phase, stall reads twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= BUS_IDLE;
      addr_q <= '0;
      be_q <= '0;
      wr_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          wr_pend_q <= acc && hwrite;
          if (acc) begin
            addr_q <= haddr[11:0];
            be_q <= lanes(hsize, haddr[1:0]);
          end
          // read: hold ready low while memory answers
          if (acc && !hwrite) begin
            state_q <= BUS_RD_MEM;
            hreadyout_q <= 1'b0;
          end
        end
        BUS_RD_MEM: begin
          state_q <= BUS_RD_OUT;
        end
        BUS_RD_OUT: begin
          state_q <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
        default: begin
          state_q <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // memory port: write commit or read, never both in one cycle
  logic [3:0] ram_we;
  logic ram_en;
  logic [31:0] ram_rdata;
  assign ram_we = (wr_commit && !to_reg) ? be_q : 4'h0;
  assign ram_en = (state_q == BUS_RD_MEM) && !to_reg;

  // buffer space, endpoint-0 buffers, setup block and descriptors
  buffer_ram #(
    .AW(usb_fc_pkg::RAM_AW),
    .DW(32)
  ) u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(ram_en),
    .we(ram_we),
    .addr(addr_q[10:2]),
    .wdata(hwdata),
    .rdata_q(ram_rdata)
  );

  // frame number tracking
  frame_tracker #(
    .FW(usb_fc_pkg::FRAME_W)
  ) u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .soft_rst(soft_rst),
    .sof(usb_evt.sof),
    .sof_frame(usb_evt.sof_frame),
    .pseudo_sof(usb_evt.pseudo_sof),
    .locked(usb_evt.frame_locked),
    .frame_q(frame_q)
  );

  // register read mux; reserved and unmapped bits read zero
  logic [31:0] reg_rdata;
  assign reg_rdata =
    hit(addr_q, usb_fc_pkg::OFS_FRAME) ? {21'h0, frame_q} :
    hit(addr_q, usb_fc_pkg::OFS_CTL) ? {24'h0, ctl_q} :
    hit(addr_q, usb_fc_pkg::OFS_IE) ? {24'h0, ie_q} :
    hit(addr_q, usb_fc_pkg::OFS_FLAGS) ? {24'h0, flags_q} :
    hit(addr_q, usb_fc_pkg::OFS_DEVADR) ? {25'h0, adr_q} :
    hit(addr_q, usb_fc_pkg::OFS_MODEN) ? {31'h0, moden_q} :
    hit(addr_q, usb_fc_pkg::OFS_TSTAMP) ? {16'h0, ts_q} :
    32'h0;

  // read data registered once the memory has answered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
      hresp_q <= 1'b0;
    end else if (state_q == BUS_RD_OUT) begin
      hrdata_q <= to_reg ? reg_rdata : ram_rdata;
    end
  end

  // control next value; wakeup request lives one cycle only
  logic [7:0] ctl_d;
  always_comb begin
    ctl_d = ctl_q;
    ctl_d[usb_fc_pkg::BIT_REMOTE_WAKEUP_REQUEST] = 1'b0;
    if (wr_ctl) begin
      ctl_d = wbyte & usb_fc_pkg::CTL_MASK;
    end
    if (soft_rst) begin
      // keep the connection bit so later resets still reach us
      ctl_d = ctl_q & (8'h01 << usb_fc_pkg::BIT_BUS_RESET_RESETS_MODULE);
    end
    if (usb_evt.bus_reset) begin
      ctl_d[usb_fc_pkg::BIT_FEN] = 1'b0;
    end
  end

  // events that set flags this cycle
  logic [7:0] ev_set;
  always_comb begin
    ev_set = 8'h00;
    ev_set[usb_fc_pkg::BIT_EV_RST] = usb_evt.bus_reset;
    ev_set[usb_fc_pkg::BIT_EV_SUS] = usb_evt.suspend;
    ev_set[usb_fc_pkg::BIT_EV_RES] = usb_evt.resume;
    ev_set[usb_fc_pkg::BIT_EV_SETUP] = usb_evt.setup;
    // a new setup while the block still holds one overwrites it
    ev_set[usb_fc_pkg::BIT_EV_STPOW] = usb_evt.setup &&
      flags_q[usb_fc_pkg::BIT_EV_SETUP];
  end

  // flags: software write, module reset, then set wins over clear
  logic [7:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = wbyte & usb_fc_pkg::EV_MASK;
    end
    if (soft_rst) begin
      flags_d = flags_d & (8'h01 << usb_fc_pkg::BIT_EV_RST);
    end
    flags_d = flags_d | ev_set;
  end

  // register file
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= usb_fc_pkg::CTL_RST;
      ie_q <= usb_fc_pkg::EV_RST;
      flags_q <= usb_fc_pkg::EV_RST;
      adr_q <= usb_fc_pkg::ADR_RST;
      moden_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      flags_q <= flags_d;
      if (soft_rst) begin
        ie_q <= usb_fc_pkg::EV_RST;
        adr_q <= usb_fc_pkg::ADR_RST;
      end else begin
        if (wr_ie) begin
          ie_q <= wbyte & usb_fc_pkg::EV_MASK;
        end
        if (wr_adr) begin
          adr_q <= wbyte[6:0];
        end
      end
      if (wr_moden) begin
        moden_q <= wbyte[usb_fc_pkg::BIT_MODEN];
      end
    end
  end

  // timestamp capture, read only to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_q <= usb_fc_pkg::TS_RST;
    end else if (ts_trigger) begin
      ts_q <= timer_value;
    end
  end

  // function-side outputs, each one register deep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
      modrst_q <= 1'b0;
      nak_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wake_q <= ctl_q[usb_fc_pkg::BIT_REMOTE_WAKEUP_REQUEST];
      modrst_q <= soft_rst;
      nak_q <= flags_q[usb_fc_pkg::BIT_EV_SETUP];
      irq_q <= |(flags_q & ie_q);
    end
  end

  // port drives
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign txn_enable = ctl_q[usb_fc_pkg::BIT_FEN];
  assign ep0_force_nak = nak_q;
  assign wakeup_pulse = wake_q;
  assign module_reset = modrst_q;
  assign data_dir_in = ctl_q[usb_fc_pkg::BIT_DIR];
  assign device_address = adr_q;
  assign irq = irq_q;

  // checks, all on hclk
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_FN_LOAD: assert property (
    usb_evt.sof && !soft_rst |=> frame_q == $past(usb_evt.sof_frame))
    else $error("frame number not loaded from start-of-frame");

  AST_FN_STEP: assert property (
    usb_evt.pseudo_sof && !usb_evt.frame_locked && !usb_evt.sof &&
    !soft_rst |=> frame_q == 11'($past(frame_q) + 11'h1))
    else $error("frame number did not step on pseudo frame");

  AST_FEN_CLR: assert property (
    usb_evt.bus_reset |=> !txn_enable ##1 (!txn_enable || $past(wr_ctl)))
    else $error("bus reset left function enabled");

  AST_WAKE: assert property (
    $rose(ctl_q[usb_fc_pkg::BIT_REMOTE_WAKEUP_REQUEST]) |-> ##1 wakeup_pulse &&
    ($past(wr_ctl) || !ctl_q[usb_fc_pkg::BIT_REMOTE_WAKEUP_REQUEST]))
    else $error("wakeup request not pulsed and cleared");

  AST_SOFT_RST: assert property (
    usb_evt.bus_reset && ctl_q[usb_fc_pkg::BIT_BUS_RESET_RESETS_MODULE] |=>
    device_address == 7'h00 && module_reset)
    else $error("connected bus reset did not reset module");

  AST_NO_SOFT_RST: assert property (
    usb_evt.bus_reset && !ctl_q[usb_fc_pkg::BIT_BUS_RESET_RESETS_MODULE] |=>
    !module_reset)
    else $error("module reset without connection bit");

  AST_IRQ: assert property (
    (flags_q[usb_fc_pkg::BIT_EV_SETUP] && ie_q[usb_fc_pkg::BIT_EV_SETUP])
    |=> irq)
    else $error("enabled setup flag raised no interrupt");

  AST_RST_FLAG: assert property (
    usb_evt.bus_reset |=> flags_q[usb_fc_pkg::BIT_EV_RST])
    else $error("bus reset flag not set");

  AST_NAK: assert property (
    flags_q[usb_fc_pkg::BIT_EV_SETUP] |=> ep0_force_nak)
    else $error("endpoint 0 not forced to nak");

  AST_STPOW: assert property (
    usb_evt.setup && flags_q[usb_fc_pkg::BIT_EV_SETUP] |=>
    flags_q[usb_fc_pkg::BIT_EV_STPOW])
    else $error("setup overwrite not flagged");

  AST_LOCKED: assert property (
    wr_commit && to_reg && !moden_q && !usb_evt.bus_reset |=>
    $stable(device_address) && $stable(ie_q))
    else $error("register written while module disabled");

  AST_RSVD: assert property (
    (flags_q & ~usb_fc_pkg::EV_MASK) == 8'h00 &&
    (ctl_q & ~usb_fc_pkg::CTL_MASK) == 8'h00)
    else $error("reserved bit set");

  AST_TSTAMP: assert property (
    ts_trigger |=> ts_q == $past(timer_value))
    else $error("timestamp not captured");

endmodule // usb_fc_top

//--- usb_fc_pkg.sv
/*
  Shared constants and types of the USB function control block:
  register offsets, bit positions, masks, reset values, buffer map
  and the event bundle from the serial engine.
  Assumes a 12-bit byte address window behind one AHB-Lite select.
*/
package usb_fc_pkg;

  // bus window
  localparam int ADDR_W = 12;
  localparam int RAM_AW = 9;

  // register byte offsets, above the buffer memory
  localparam logic [11:0] OFS_FRAME = 12'h800;
  localparam logic [11:0] OFS_CTL = 12'h804;
  localparam logic [11:0] OFS_IE = 12'h808;
  localparam logic [11:0] OFS_FLAGS = 12'h80C;
  localparam logic [11:0] OFS_DEVADR = 12'h810;
  localparam logic [11:0] OFS_MODEN = 12'h814;
  localparam logic [11:0] OFS_TSTAMP = 12'h818;

  // buffer memory map, byte offsets
  localparam logic [11:0] BUF_SPACE_START = 12'h000;
  localparam logic [11:0] BUF_SPACE_END = 12'h76F;
  localparam logic [11:0] EP0_OUT_BUF = 12'h770;
  localparam logic [11:0] EP0_IN_BUF = 12'h778;
  localparam logic [11:0] SETUP_BLK = 12'h780;
  localparam logic [11:0] SETUP_BLK_END = 12'h787;
  localparam logic [11:0] DESC_END = 12'h7FF;

  // control and module enable register fields
  localparam int BIT_FEN = 6;
  localparam int BIT_REMOTE_WAKEUP_REQUEST = 5;
  localparam int BIT_BUS_RESET_RESETS_MODULE = 4;
  localparam int BIT_DIR = 0;
  localparam int BIT_MODEN = 0;

  // event flag and enable fields
  localparam int BIT_EV_RST = 7;
  localparam int BIT_EV_SUS = 6;
  localparam int BIT_EV_RES = 5;
  localparam int BIT_EV_SETUP = 2;
  localparam int BIT_EV_STPOW = 0;

  // writable masks; reserved bits read zero
  localparam logic [7:0] CTL_MASK = 8'h71;
  localparam logic [7:0] EV_MASK = 8'hE5;
  localparam logic [7:0] ADR_MASK = 8'h7F;

  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] EV_RST = 8'h00;
  localparam logic [6:0] ADR_RST = 7'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;
  localparam logic [15:0] TS_RST = 16'h0000;

  // widths
  localparam int FRAME_W = 11;
  localparam int TS_W = 16;

  // one-cycle events and levels from the serial engine, same clock
  typedef struct packed {
    logic sof;
    logic [10:0] sof_frame;
    logic pseudo_sof;
    logic frame_locked;
    logic bus_reset;
    logic suspend;
    logic resume;
    logic setup;
  } usb_evt_t;

endpackage

//--- buffer_ram.sv
/*
  Single-port buffer memory with per-byte write lanes and a
  registered read port.
  Assumes one access per cycle; read data appear one edge later.
*/
`timescale 1ns/100ps
module buffer_ram #(
  parameter int AW = 9,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // access port
  input wire logic en,
  input wire logic [DW/8-1:0] we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);

  // storage, no reset so it maps onto ram macros
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // one lane per byte, so byte, half and word writes all work;
  // a single process keeps the array to one driver
  always_ff @(posedge hclk) begin
    for (int b = 0; b < DW/8; b++) begin
      if (we[b]) begin
        mem[addr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  // read data out of a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (en) begin
      rdata_q <= mem[addr];
    end
  end

endmodule // buffer_ram

//--- frame_tracker.sv
/*
  Frame number tracker: loads the frame field of each start-of-frame
  and steps on pseudo start-of-frame while the frame timer is unlocked.
  Assumes event inputs are single-cycle pulses on hclk.
*/
`timescale 1ns/100ps
module frame_tracker #(
  parameter int FW = 11
) (
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic soft_rst,
  // frame events
  input wire logic sof,
  input wire logic [FW-1:0] sof_frame,
  input wire logic pseudo_sof,
  input wire logic locked,
  // current frame
  output logic [FW-1:0] frame_q
);

  // a real packet wins over a pseudo tick in the same cycle
  logic [FW-1:0] frame_d;
  assign frame_d = sof ? sof_frame :
    (pseudo_sof && !locked) ? frame_q + FW'(1) : frame_q;

  // counter register, wraps at the field width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_q <= '0;
    end else if (soft_rst) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

endmodule // frame_tracker

//--- usb_host_model.sv
/*
  Behavioural host on the bus side of the function control block: turns
  bench requests into the one-cycle event pulses and the frame field
  that the serial engine hands on.
  Assumes requests are one-cycle strobes raised just after an hclk edge.
*/
`timescale 1ns/100ps
module usb_host_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench requests
  input wire logic ev_go,
  input wire logic [2:0] ev_kind,
  input wire logic [10:0] ev_frame,
  input wire logic locked,
  // events toward the device
  output usb_fc_pkg::usb_evt_t usb_evt
);
  // decoded request strobes: 0 sof, 1 pseudo sof, 2 bus reset, 3 suspend, 4 resume, 5 setup
  wire logic go_sof = ev_go && ev_kind == 3'h0;
  wire logic go_psof = ev_go && ev_kind == 3'h1;
  wire logic go_rst = ev_go && ev_kind == 3'h2;
  wire logic go_sus = ev_go && ev_kind == 3'h3;
  wire logic go_res = ev_go && ev_kind == 3'h4;
  wire logic go_setup = ev_go && ev_kind == 3'h5;

  // every event lasts exactly one cycle, as the serial engine delivers it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      usb_evt <= '0;
    end else begin
      usb_evt.sof <= go_sof;
      // outside a sof the field toggles, so a stale frame is never trusted
      usb_evt.sof_frame <= go_sof ? ev_frame : ~usb_evt.sof_frame;
      usb_evt.pseudo_sof <= go_psof;
      usb_evt.frame_locked <= locked;
      usb_evt.bus_reset <= go_rst;
      usb_evt.suspend <= go_sus;
      usb_evt.resume <= go_res;
      usb_evt.setup <= go_setup;
    end
  end
endmodule // usb_host_model

//--- tb.sv
/*
  Self-checking bench of the function control block: an AHB-Lite master,
  the host model on the event side and a read monitor fed by a queue.
  Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb;
  // clock, reset and bus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  // event side and function outputs
  usb_fc_pkg::usb_evt_t usb_evt;
  logic ts_trigger = 1'b0;
  logic [15:0] timer_value = 16'h0;
  logic txn_enable, ep0_force_nak, wakeup_pulse, module_reset, data_dir_in, irq;
  logic [6:0] device_address;
  logic ev_go = 1'b0;
  logic [2:0] ev_kind = 3'h0;
  logic [10:0] ev_frame = 11'h0;
  logic locked = 1'b0;
  // bookkeeping
  int fails = 0;
  int cmp_count = 0;
  int wk_n = 0;
  int mr_n = 0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  logic [6:0] a7;
  logic [11:0] regs [5] = '{usb_fc_pkg::OFS_FRAME, usb_fc_pkg::OFS_CTL, usb_fc_pkg::OFS_IE,
    usb_fc_pkg::OFS_FLAGS, usb_fc_pkg::OFS_DEVADR};
  logic [11:0] mem [5] = '{12'h000, 12'h76C, usb_fc_pkg::EP0_OUT_BUF, usb_fc_pkg::EP0_IN_BUF, 12'h7FC};
  logic [7:0] fl [4] = '{8'h80, 8'h40, 8'h20, 8'h04};

  initial forever #5 hclk = ~hclk;

  usb_fc_top u_usb_fc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .usb_evt(usb_evt), .ts_trigger(ts_trigger), .timer_value(timer_value),
    .txn_enable(txn_enable), .ep0_force_nak(ep0_force_nak), .wakeup_pulse(wakeup_pulse),
    .module_reset(module_reset), .data_dir_in(data_dir_in), .device_address(device_address), .irq(irq));
  usb_host_model u_usb_host_model (.hclk(hclk), .hresetn(hresetn), .ev_go(ev_go), .ev_kind(ev_kind),
    .ev_frame(ev_frame), .locked(locked), .usb_evt(usb_evt));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: bus hang", $time);
      wrap_up();
    end
  endtask

  // one single transfer, entered just after an edge; a read notes its expectation
  task automatic bus(input logic w, input logic [11:0] a, input logic [2:0] sz, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) exp_q.push_back(d);
    wait_rdy();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, 3'h2, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 3'h2, e);
  endtask

  // ask the host model for one event, then let flags and irq settle
  task automatic ev(input logic [2:0] k);
    ev_go <= 1'b1;
    ev_kind <= k;
    @(posedge hclk);
    ev_go <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  // monitor: the oldest note is taken when a read's data phase ends
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      cmp(hrdata, exp_q.pop_front());
      cmp({31'h0, hresp}, 32'h0);
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend = 1'b1;
    if (wakeup_pulse === 1'b1) wk_n++;
    if (module_reset === 1'b1) mr_n++;
  end

  initial begin
    void'($urandom(3988));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, then an unmapped place
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(12'hFFC, 32'h0);
    // register writes need the module enabled first
    wr(usb_fc_pkg::OFS_CTL, 32'h40);
    rd(usb_fc_pkg::OFS_CTL, 32'h0);
    wr(usb_fc_pkg::OFS_MODEN, 32'h1);
    wr(usb_fc_pkg::OFS_CTL, 32'hFFFF_FFDF);
    rd(usb_fc_pkg::OFS_CTL, 32'h51);
    cmp({31'h0, txn_enable}, 32'h1);
    cmp({31'h0, data_dir_in}, 32'h1);
    // wakeup request gives one pulse and clears itself
    wr(usb_fc_pkg::OFS_CTL, 32'h60);
    repeat (4) @(posedge hclk);
    cmp(wk_n, 32'h1);
    wr(usb_fc_pkg::OFS_CTL, 32'h40);
    rd(usb_fc_pkg::OFS_CTL, 32'h40);
    cmp(wk_n, 32'h1);
    cmp({31'h0, data_dir_in}, 32'h0);
    // device address: random, then both ends of the range; upper bits junk
    for (int i = 0; i < 3; i++) begin
      a7 = (i == 0) ? 7'($urandom) : (i == 1) ? 7'h00 : 7'h7F;
      wr(usb_fc_pkg::OFS_DEVADR, {25'($urandom), a7});
      rd(usb_fc_pkg::OFS_DEVADR, {25'h0, a7});
      cmp({25'h0, device_address}, {25'h0, a7});
    end
    // frame number from sof, then a step on pseudo sof while unlocked
    ev_frame <= 11'($urandom);
    ev(3'h0);
    rd(usb_fc_pkg::OFS_FRAME, {21'h0, ev_frame});
    ev(3'h1);
    rd(usb_fc_pkg::OFS_FRAME, {21'h0, 11'(ev_frame + 11'h1)});
    // a locked frame timer ignores the pseudo tick
    locked <= 1'b1;
    ev(3'h1);
    locked <= 1'b0;
    rd(usb_fc_pkg::OFS_FRAME, {21'h0, 11'(ev_frame + 11'h1)});
    // timestamp latch; the timer moves on afterwards
    timer_value <= 16'($urandom);
    ts_trigger <= 1'b1;
    @(posedge hclk);
    ts_trigger <= 1'b0;
    r = {16'h0, timer_value};
    timer_value <= ~timer_value;
    rd(usb_fc_pkg::OFS_TSTAMP, r);
    // each event sets its flag and, enabled, the irq
    wr(usb_fc_pkg::OFS_IE, 32'hFF);
    rd(usb_fc_pkg::OFS_IE, 32'hE5);
    for (int k = 2; k < 6; k++) begin
      wr(usb_fc_pkg::OFS_FLAGS, 32'h0);
      ev(3'(k));
      rd(usb_fc_pkg::OFS_FLAGS, {24'h0, fl[k-2]});
      cmp({31'h0, irq}, 32'h1);
      if (k == 2) cmp({31'h0, txn_enable}, 32'h0);
      if (k == 2) cmp(mr_n, 32'h0);
      if (k == 2) cmp({25'h0, device_address}, 32'h7F);
    end
    cmp({31'h0, ep0_force_nak}, 32'h1);
    ev(3'h5);
    rd(usb_fc_pkg::OFS_FLAGS, 32'h05);
    // only reserved enable bits: irq must drop
    wr(usb_fc_pkg::OFS_IE, 32'h1A);
    repeat (2) @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
    wr(usb_fc_pkg::OFS_FLAGS, 32'h0);
    repeat (2) @(posedge hclk);
    cmp({31'h0, ep0_force_nak}, 32'h0);
    // connected bus reset: module logic reset, reset flag kept
    wr(usb_fc_pkg::OFS_CTL, 32'h10);
    wr(usb_fc_pkg::OFS_IE, 32'h80);
    ev(3'h2);
    cmp(mr_n, 32'h1);
    cmp({25'h0, device_address}, 32'h0);
    rd(usb_fc_pkg::OFS_FLAGS, 32'h80);
    rd(usb_fc_pkg::OFS_IE, 32'h0);
    rd(usb_fc_pkg::OFS_CTL, 32'h10);
    // buffer memory: all words first, then read back to catch aliasing
    r = $urandom;
    foreach (mem[i]) wr(mem[i], r ^ i);
    foreach (mem[i]) rd(mem[i], r ^ i);
    wr(12'h784, r);
    bus(1'b1, usb_fc_pkg::SETUP_BLK_END, 3'h0, {~r[31:24], 24'h0});
    rd(12'h784, {~r[31:24], r[23:0]});
    wrap_up();
  end
endmodule // tb
